// [design/tws_eeprom_slave.sv]
// Two-wire serial memory target: bus decode, paging, protection, write cycle
`timescale 1ns/100ps

// Overview of operation
// - Sample on clock rise, drive after fall
// - Data line only pulled low or released
// - Small part: three strap bits select device
// - Large part: two upper straps, lowest ignored
// - Protect low: whole array writable
// - Protect high: upper half not written
// - Small part: 8-byte pages, 8-bit address
// - Large part: 16-byte pages, 9-bit address
// - Data fall with clock high is start
// - Data rise with clock high is stop
// - Stop after read enters standby
// - Acknowledge each received word on ninth clock
// - Standby at reset and after finished stop
// - Start, nine clocks, start, stop recovers
// - Self-timed write cycle at most 5 ms
// - Full or partial page writes accepted
// - Glitches up to 50 ns filtered out
// - Works with clock up to 400 kHz
// - Device byte: prefix, selects, direction bit
// - Page write wraps inside the page
// - Busy programming: inputs ignored, no acknowledge
// - Sequential read increments, wraps, ends on nack
module tws_eeprom_slave
   import tws_pkg::*;
#(
   parameter bit LARGE       = 1'h0,
   parameter int PROG_CYCLES = tws_pkg::PROG_CYC
) (
   input  logic                   SYS_CLK,
   input  logic                   RESET,
   input  logic                   SCL,
   input  logic                   SDA_I,
   output logic                   SDA_O,
   output logic                   SDA_OE,
   input  logic                   CHIP_SELECT_BIT0,
   input  logic                   CHIP_SELECT_BIT1,
   input  logic                   CHIP_SELECT_BIT2,
   input  logic                   WRITE_PROTECT,
   output tws_pkg::tws_addr_t     MEM_RADDR,
   input  logic [7:0]             MEM_RDATA,
   output tws_pkg::tws_mem_wr_s   MEM_WR,
   output logic                   STANDBY,
   output logic                   BUSY
);
   import tws_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0]            m1;       // {data, clock} first sync stage
      logic [1:0]            m2;
      logic [1:0]            flt;      // filtered levels
      logic [1:0]            prev;     // filtered levels one cycle ago
      logic [1:0][2:0]       cnt;      // glitch counters
      logic [2:0]            cs_m1;
      logic [2:0]            cs_m2;
      logic                  wp_m1;
      logic                  wp_m2;
      tws_state_e            st;
      logic [3:0]            bitcnt;
      logic [7:0]            shreg;
      tws_addr_t             addr;
      logic                  a8;
      logic                  sda_oe;
      logic                  ack_ok;
      logic [PROG_CNT_W-1:0] prog_cnt;
      tws_mem_wr_s           mwr;
   } tws_top_s;

   tws_top_s    q;
   tws_top_s    d;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic        dev_match;
   logic        wr_protected;
   tws_addr_t   page_mask;
   tws_addr_t   array_mask;
   tws_addr_t   half_mask;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   tws_wentry_s fifo_in;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   tws_wentry_s fifo_out;

   localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES - 1);

   // ------------------------------------------------------------
   // Bus events and decode
   // ------------------------------------------------------------
   // Events come from filtered levels, so a spike never looks like an edge
   assign scl_rise = q.flt[0] & ~q.prev[0];
   assign scl_fall = ~q.flt[0] & q.prev[0];
   assign start_c  = q.flt[0] & q.prev[0] & q.prev[1] & ~q.flt[1];
   assign stop_c   = q.flt[0] & q.prev[0] & ~q.prev[1] & q.flt[1];

   // Geometry per variant
   assign page_mask  = LARGE ? PAGE_MASK_LARGE : PAGE_MASK_SMALL;
   assign array_mask = LARGE ? ARRAY_MASK_LARGE : ARRAY_MASK_SMALL;
   assign half_mask  = LARGE ? HALF_LARGE : HALF_SMALL;

   // device byte compare; large part skips the lowest strap
   assign dev_match = (q.shreg[7:4] == TYPE_PREFIX) &&
                      (LARGE ? (q.shreg[3:2] == q.cs_m2[2:1])
                             : (q.shreg[3:1] == q.cs_m2));
   // upper half locked while protect is high
   assign wr_protected = q.wp_m2 && ((q.addr & half_mask) != '0);

   // outputs; pin only ever pulled low
   assign SDA_O     = 1'h0;
   assign SDA_OE    = q.sda_oe;
   assign MEM_RADDR = q.addr;
   assign MEM_WR    = q.mwr;
   assign STANDBY   = (q.st == ST_IDLE);
   assign BUSY      = (q.st == ST_PROG);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      d              = q;
      d.mwr.we       = 1'h0;
      fifo_in_valid  = 1'h0;
      fifo_in        = '{addr: q.addr, data: q.shreg};
      fifo_out_ready = 1'h0;

      // two-stage sync of pins before any logic looks at them
      d.m1    = {SDA_I, SCL};
      d.m2    = q.m1;
      d.cs_m1 = {CHIP_SELECT_BIT2, CHIP_SELECT_BIT1, CHIP_SELECT_BIT0};
      d.cs_m2 = q.cs_m1;
      d.wp_m1 = WRITE_PROTECT;
      d.wp_m2 = q.wp_m1;
      d.prev  = q.flt;

      // level must differ for more than 50 ns before it counts
      for (int i = 0; i < 2; i++) begin
         if (q.m2[i] == q.flt[i]) begin
            d.cnt[i] = '0;
         end else if (q.cnt[i] == GLITCH_CNT) begin
            d.flt[i] = q.m2[i];
            d.cnt[i] = '0;
         end else begin
            d.cnt[i] = q.cnt[i] + 3'h1;
         end
      end

      if (q.st == ST_PROG) begin
         // self-timed cycle; bus ignored until it ends
         fifo_out_ready = 1'h1;
         if (fifo_out_valid) begin
            d.mwr = '{we: 1'h1, addr: fifo_out.addr, data: fifo_out.data};
         end
         d.sda_oe = 1'h0;
         if (q.prog_cnt == PROG_LAST) begin
            d.prog_cnt = '0;
            d.st       = ST_IDLE;
         end else begin
            d.prog_cnt = q.prog_cnt + 1'h1;
         end
      end else if (start_c) begin
         // any start restarts the decoder from scratch
         d.st     = ST_DEVADR;
         d.bitcnt = '0;
         d.sda_oe = 1'h0;
      end else if (stop_c) begin
         // stop ends the transfer; buffered data starts a write cycle
         d.bitcnt = '0;
         d.sda_oe = 1'h0;
         d.st     = (q.st == ST_WDATA && fifo_out_valid) ? ST_PROG : ST_IDLE;
      end else begin
         unique case (q.st)
            ST_IDLE, ST_SKIP: begin
               d.sda_oe = 1'h0;
            end
            ST_DEVADR, ST_WORDADR, ST_WDATA: begin
               if (scl_rise && q.bitcnt < BITS_PER_WORD) begin
                  d.shreg  = {q.shreg[6:0], q.flt[1]};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == BITS_PER_WORD) begin
                  d.bitcnt = ACK_SLOT;
                  unique case (q.st)
                     ST_DEVADR: begin
                        if (dev_match) begin
                           d.sda_oe = 1'h1;
                           d.ack_ok = 1'h1;
                           d.a8     = LARGE & q.shreg[1];
                           d.st     = q.shreg[0] ? ST_RDATA : ST_WORDADR;
                        end else begin
                           d.st = ST_SKIP;
                        end
                     end
                     ST_WORDADR: begin
                        // 8-bit address; large part takes ninth bit from device byte, small part sets it to 0
                        d.sda_oe = 1'h1;
                        d.addr   = LARGE ? {q.a8, q.shreg} : {1'h0, q.shreg};
                        d.st     = ST_WDATA;
                     end
                     default: begin
                        // each unprotected byte of a full or partial page is buffered
                        if (fifo_in_ready) begin
                           d.sda_oe      = 1'h1;
                           fifo_in_valid = !wr_protected;
                           d.addr = (q.addr & ~page_mask) |
                                    ((q.addr + 9'h001) & page_mask);
                        end
                     end
                  endcase
               end else if (scl_fall && q.bitcnt == ACK_SLOT) begin
                  // Ack slot ends on the ninth fall
                  d.sda_oe = 1'h0;
                  d.bitcnt = '0;
               end
            end
            ST_RDATA: begin
               if (scl_fall && q.bitcnt == ACK_SLOT) begin
                  if (q.ack_ok) begin
                     // next byte; address wraps at the array end
                     d.shreg  = MEM_RDATA;
                     d.sda_oe = ~MEM_RDATA[7];
                     d.addr   = (q.addr + 9'h001) & array_mask;
                     d.bitcnt = '0;
                  end else begin
                     d.sda_oe = 1'h0;
                     d.st     = ST_SKIP;
                  end
               end else if (scl_rise && q.bitcnt == BITS_PER_WORD) begin
                  // Controller ack sampled on the ninth rise
                  d.ack_ok = ~q.flt[1];
                  d.bitcnt = ACK_SLOT;
               end else if (scl_rise && q.bitcnt < BITS_PER_WORD) begin
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == BITS_PER_WORD) begin
                  d.sda_oe = 1'h0;
               end else if (scl_fall && q.bitcnt != '0) begin
                  // next bit shifted out after the fall
                  d.shreg  = {q.shreg[6:0], 1'h0};
                  d.sda_oe = ~q.shreg[6];
               end
            end
            default: begin
               d.st = ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // reset lands in standby with both lines seen idle high
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         q       <= '0;
         q.m1    <= LINES_IDLE;
         q.m2    <= LINES_IDLE;
         q.flt   <= LINES_IDLE;
         q.prev  <= LINES_IDLE;
         q.cs_m1 <= STRAPS_RST;
         q.cs_m2 <= STRAPS_RST;
         q.st    <= ST_IDLE;
      end else begin
         q <= d;
      end
   end

   // Page buffer; the write cycle drains it into the array
   tws_fifo #(
      .WIDTH ($bits(tws_wentry_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_wbuf (
      .clk       (SYS_CLK),
      .rst       (RESET),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   sequence s_word_in;
      scl_fall && q.bitcnt == BITS_PER_WORD && q.st == ST_WORDADR;
   endsequence
   sequence s_ack_held;
      q.sda_oe && q.bitcnt == ACK_SLOT;
   endsequence

   drive_after_fall_a:
   assert property ($rose(q.sda_oe) |-> $past(scl_fall)) else $error("drive not after a fall");
   open_drain_a:
   assert property (SDA_O == 1'h0 && !(SDA_OE && q.st inside {ST_IDLE, ST_SKIP, ST_PROG}))
      else $error("data line driven when it must be released");
   dev_nack_a:
   assert property (scl_fall && q.bitcnt == BITS_PER_WORD && q.st == ST_DEVADR && !dev_match
                    |=> !q.sda_oe && q.st == ST_SKIP) else $error("foreign address acked");
   word_ack_a:
   assert property (s_word_in |=> s_ack_held) else $error("word address not acked");
   start_decode_a:
   assert property (start_c && q.st != ST_PROG |=> q.st == ST_DEVADR && q.bitcnt == '0)
      else $error("start not taken");
   stop_standby_a:
   assert property (stop_c && q.st inside {ST_RDATA, ST_SKIP, ST_WORDADR} |=> STANDBY)
      else $error("no standby after stop");
   prog_length_a:
   assert property ($fell(BUSY) |-> $past(q.prog_cnt) == PROG_LAST)
      else $error("write cycle length wrong");
   busy_nack_a:
   assert property (BUSY |-> !SDA_OE) else $error("acked while programming");
   protect_upper_a:
   assert property (fifo_in_valid && q.wp_m2 |-> (fifo_in.addr & half_mask) == '0)
      else $error("protected half written");
   page_wrap_a:
   assert property (fifo_in_valid |=> (q.addr & ~page_mask) == ($past(q.addr) & ~page_mask))
      else $error("page row changed during write");
   read_wrap_a:
   assert property (scl_fall && q.st == ST_RDATA && q.bitcnt == ACK_SLOT && q.ack_ok
                    |=> q.addr == (($past(q.addr) + 9'h001) & array_mask))
      else $error("read address did not advance");
   glitch_filter_a:
   assert property ($changed(q.flt[0]) |-> $past(q.m2[0], 1) == q.flt[0] &&
                    $past(q.m2[0], 6) == q.flt[0]) else $error("clock glitch passed");

endmodule

// [design/tws_fifo.sv]
// Write buffer FIFO with registered head word
`timescale 1ns/100ps
module tws_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = tws_pkg::FIFO_DEPTH
) (
   input  logic             clk,
   input  logic             rst,
   input  logic             in_valid,
   output logic             in_ready,
   input  logic [WIDTH-1:0] in_data,
   output logic             out_valid,
   input  logic             out_ready,
   output logic [WIDTH-1:0] out_data
);
   import tws_pkg::*;

   // DEPTH must be a power of two so the pointers wrap on their own
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wptr;
      logic [PW-1:0]               rptr;
      logic [PW:0]                 count;
      logic [WIDTH-1:0]            head;
   } tws_fifo_s;

   tws_fifo_s     q;
   tws_fifo_s     d;
   logic          push;
   logic          pop;
   logic [PW-1:0] rptr_n;

   // Honest flags straight from the count
   assign in_ready  = (q.count != (PW + 1)'(DEPTH));
   assign out_valid = (q.count != '0);
   assign out_data  = q.head;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Next state; head bypasses the array when the new word is next out
   always_comb begin
      d      = q;
      rptr_n = pop ? q.rptr + 1'h1 : q.rptr;
      if (push) begin
         d.mem[q.wptr] = in_data;
         d.wptr        = q.wptr + 1'h1;
      end
      d.rptr = rptr_n;
      d.head = (push && q.wptr == rptr_n) ? in_data : q.mem[rptr_n];
      if (push && !pop) begin
         d.count = q.count + 1'h1;
      end else if (pop && !push) begin
         d.count = q.count - 1'h1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   no_overflow_a:
   assert property (q.count <= (PW + 1)'(DEPTH)) else $error("fifo count past depth");
   full_stalls_a:
   assert property (!in_ready |=> q.count == $past(q.count) - (PW + 1)'($past(pop)))
      else $error("fifo accepted while full");

endmodule

// [dv/tws_bus_ctrl.sv]
// Behavioural two-wire bus controller driving the memory target
`timescale 1ns/100ps
module tws_bus_ctrl #(
   parameter int QTR = 8
) (
   input  wire logic clk,
   output logic      scl,
   output logic      sda_oe,
   input  wire logic sda
);
   // ------------------------------------------------------------
   // Line control
   // ------------------------------------------------------------
   // Idle: clock high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   // Phases are 160 ns, above the target's filter plus answer delay
   task automatic q(input int n);
      repeat (n * QTR) @(negedge clk);
   endtask

   task automatic start();
      sda_oe = 1'b0;
      q(1);
      scl = 1'b1;
      q(2);
      sda_oe = 1'b1;
      q(2);
      scl = 1'b0;
      q(1);
   endtask

   task automatic stop();
      sda_oe = 1'b1;
      q(1);
      scl = 1'b1;
      q(2);
      sda_oe = 1'b0;
      q(4);
   endtask

   // data changes only while clock low, open-drain
   task automatic bit_io(input logic b, output logic r);
      sda_oe = !b;
      q(1);
      scl = 1'b1;
      q(2);
      r = sda;
      scl = 1'b0;
      q(1);
   endtask

   // most significant bit first, ninth clock is acknowledge
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, ack);
   endtask

   // controller acknowledges to continue, withholds to end
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
   endtask
endmodule

// [dv/tws_eeprom_slave_tb.sv]
// Self-checking bench of the two-wire serial memory target
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tws_eeprom_slave_tb;
   import tws_pkg::*;
   localparam int         PROG  = 2000;
   localparam logic [2:0] STRAP = 3'h5;
   localparam logic [1:0] STRAP_L = 2'h3;
   logic        sys_clk = 1'b0;
   logic        reset   = 1'b1;
   logic        wp      = 1'b0;
   wire         scl;
   wire         mst_oe;
   wire         sda_oe;
   wire         sda_o;
   wire         sda_oe_l;
   wire         sda_o_l;
   // Wired-AND line with pull-up: any driver showing a low pulls it down
   wire         sda = !(mst_oe || (sda_oe && !sda_o) || (sda_oe_l && !sda_o_l));
   tws_addr_t   raddr;
   tws_mem_wr_s mwr;
   logic        standby;
   logic        busy;
   logic [7:0]  mem [256];
   logic [7:0]  exp_mem [256];
   tws_addr_t   raddr_l;
   tws_mem_wr_s mwr_l;
   logic        standby_l;
   logic        busy_l;
   logic [7:0]  mem_l [512];
   int          num_errors = 0;
   int          checked = 0;

   // ------------------------------------------------------------
   // Clock, array model, instances
   // ------------------------------------------------------------
   always #5 sys_clk = !sys_clk;

   // Array cells follow the write port; reads are combinational
   always @(posedge sys_clk) begin
      if (mwr.we === 1'b1) mem[mwr.addr[7:0]] <= mwr.data;
      if (mwr_l.we === 1'b1) mem_l[mwr_l.addr] <= mwr_l.data;
   end

   tws_bus_ctrl u_ctl (.clk(sys_clk), .scl(scl), .sda_oe(mst_oe), .sda(sda));

   tws_eeprom_slave #(.LARGE(1'h0), .PROG_CYCLES(PROG)) dut (
      .SYS_CLK(sys_clk), .RESET(reset), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE(sda_oe), .CHIP_SELECT_BIT0(STRAP[0]), .CHIP_SELECT_BIT1(STRAP[1]),
      .CHIP_SELECT_BIT2(STRAP[2]), .WRITE_PROTECT(wp), .MEM_RADDR(raddr),
      .MEM_RDATA(mem[raddr[7:0]]), .MEM_WR(mwr), .STANDBY(standby), .BUSY(busy));

   // Large part shares the bus; its lowest strap pin must not matter
   tws_eeprom_slave #(.LARGE(1'h1), .PROG_CYCLES(PROG)) dut_l (
      .SYS_CLK(sys_clk), .RESET(reset), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o_l),
      .SDA_OE(sda_oe_l), .CHIP_SELECT_BIT0(1'b0), .CHIP_SELECT_BIT1(STRAP_L[0]),
      .CHIP_SELECT_BIT2(STRAP_L[1]), .WRITE_PROTECT(wp), .MEM_RADDR(raddr_l),
      .MEM_RDATA(mem_l[raddr_l]), .MEM_WR(mwr_l), .STANDBY(standby_l), .BUSY(busy_l));

   // ------------------------------------------------------------
   // Transfer tasks
   // ------------------------------------------------------------
   task automatic addr_dev(input logic rd, input logic [2:0] sel, output logic ack);
      u_ctl.start();
      u_ctl.wbyte({TYPE_PREFIX, sel, rd}, ack);
   endtask

   // Write n bytes, poll while busy, wait out the write cycle
   task automatic write_bytes(input logic [7:0] wa, input int n, input logic [7:0] base);
      logic ack;
      logic lock;
      int   cnt;
      // Only protected bytes queue nothing, so no write cycle follows
      lock = wp && wa[7];
      addr_dev(1'b0, STRAP, ack);
      `CHK(ack, 1'b0)
      u_ctl.wbyte(wa, ack);
      `CHK(ack, 1'b0)
      for (int i = 0; i < n; i++) begin
         u_ctl.wbyte(base + 8'(i), ack);
         `CHK(ack, 1'b0)
      end
      u_ctl.stop();
      repeat (2) @(negedge sys_clk);
      `CHK(busy, !lock)
      addr_dev(1'b0, STRAP, ack);
      `CHK(ack, !lock)
      u_ctl.stop();
      cnt = 0;
      while (busy !== 1'b0 && cnt < PROG) begin
         @(negedge sys_clk);
         cnt++;
      end
      `CHK(busy, 1'b0)
      `CHK(standby, 1'b1)
   endtask

   // Random read of n bytes from wa, checked against expected image
   task automatic read_seq(input logic [7:0] wa, input int n);
      logic       ack;
      logic [7:0] d;
      addr_dev(1'b0, STRAP, ack);
      u_ctl.wbyte(wa, ack);
      addr_dev(1'b1, STRAP, ack);
      `CHK(ack, 1'b0)
      for (int i = 0; i < n; i++) begin
         u_ctl.rbyte(i == n - 1, d);
         `CHK(d, exp_mem[wa + 8'(i)])
      end
      u_ctl.stop();
      repeat (20) @(negedge sys_clk);
      `CHK(standby, 1'b1)
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      logic       ack;
      logic [7:0] d;
      for (int i = 0; i < 512; i++) mem_l[i] = 8'(i) ^ 8'h5a;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
         exp_mem[i] = 8'(i) ^ 8'h5a;
      end
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      repeat (12) @(negedge sys_clk);
      `CHK(standby, 1'b1)
      `CHK(sda_oe, 1'b0)
      // Ten bytes into an eight-byte page: last two overwrite the first
      write_bytes(8'h86, 10, 8'h30);
      for (int i = 0; i < 10; i++) exp_mem[8'h80 | 8'((6 + i) % 8)] = 8'h30 + 8'(i);
      read_seq(8'h80, 8);
      $display("test page_wrap done");
      // Protection keeps the upper half, lower half still writable
      @(negedge sys_clk) wp = 1'b1;
      write_bytes(8'hc0, 2, 8'h77);
      write_bytes(8'h10, 1, 8'h99);
      exp_mem[8'h10] = 8'h99;
      @(negedge sys_clk) wp = 1'b0;
      read_seq(8'hc0, 2);
      read_seq(8'h10, 1);
      $display("test protect done");
      read_seq(8'hfe, 4);
      $display("test read_wrap done");
      // Other codes refused, except the pair the large part owns
      for (int s = 0; s < 8; s++) begin
         if (3'(s) != STRAP) begin
            addr_dev(1'b0, 3'(s), ack);
            `CHK(ack, 3'(s) >> 1 != 3'(STRAP_L))
            u_ctl.stop();
         end
      end
      $display("test select done");
      // Interrupted frame, then start, nine clocks, start, stop
      u_ctl.start();
      for (int i = 0; i < 3; i++) u_ctl.bit_io(1'b0, d[0]);
      u_ctl.start();
      for (int i = 0; i < 9; i++) u_ctl.bit_io(1'b1, d[0]);
      u_ctl.start();
      u_ctl.stop();
      read_seq(8'h81, 1);
      $display("test recovery done");
      // Large part: ninth address bit in the device byte, 16-byte page wraps
      addr_dev(1'b0, {STRAP_L, 1'b1}, ack);
      `CHK(ack, 1'b0)
      u_ctl.wbyte(8'hfe, ack);
      `CHK(ack, 1'b0)
      for (int i = 0; i < 3; i++) begin
         u_ctl.wbyte(8'hc0 + 8'(i), ack);
         `CHK(ack, 1'b0)
      end
      u_ctl.stop();
      repeat (2) @(negedge sys_clk);
      `CHK(busy_l, 1'b1)
      repeat (PROG) @(negedge sys_clk);
      `CHK(busy_l, 1'b0)
      `CHK(standby_l, 1'b1)
      `CHK(mem_l[9'h1fe], 8'hc0)
      `CHK(mem_l[9'h1f0], 8'hc2)
      // Random read from the last cell wraps to the first
      addr_dev(1'b0, {STRAP_L, 1'b1}, ack);
      u_ctl.wbyte(8'hff, ack);
      addr_dev(1'b1, {STRAP_L, 1'b0}, ack);
      `CHK(ack, 1'b0)
      u_ctl.rbyte(1'b0, d);
      `CHK(d, 8'hc1)
      u_ctl.rbyte(1'b1, d);
      `CHK(d, 8'h5a)
      u_ctl.stop();
      $display("test large_part done");
      complete_run();
   end

   // Watchdog sized well above the expected run of some 30000 cycles
   initial begin
      repeat (80000) @(posedge sys_clk);
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule

// [include/tws_pkg.sv]
// Shared constants and types of the two-wire serial memory target
package tws_pkg;

   // ------------------------------------------------------------
   // Array geometry and addressing
   // ------------------------------------------------------------
   localparam int         ADDR_W           = 9;
   localparam int         DATA_W           = 8;
   localparam logic [3:0] TYPE_PREFIX      = 4'ha;
   localparam logic [8:0] PAGE_MASK_SMALL  = 9'h007;
   localparam logic [8:0] PAGE_MASK_LARGE  = 9'h00f;
   localparam logic [8:0] ARRAY_MASK_SMALL = 9'h0ff;
   localparam logic [8:0] ARRAY_MASK_LARGE = 9'h1ff;
   localparam logic [8:0] HALF_SMALL       = 9'h080;
   localparam logic [8:0] HALF_LARGE       = 9'h100;
   localparam logic [3:0] BITS_PER_WORD    = 4'h8;
   localparam logic [3:0] ACK_SLOT         = 4'h9;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         GLITCH_NS     = 50;
   localparam int         GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] GLITCH_CNT    = 3'(GLITCH_CYC);
   localparam int         PROG_TIME_NS  = 5_000_000;
   localparam int         PROG_CYC      = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int         PROG_CNT_W    = 19;

   // ------------------------------------------------------------
   // Buffering and reset values
   // ------------------------------------------------------------
   localparam int         FIFO_DEPTH = 32;
   localparam logic [1:0] LINES_IDLE = 2'h3;
   localparam logic [2:0] STRAPS_RST = 3'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef logic [ADDR_W-1:0] tws_addr_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DEVADR, ST_WORDADR, ST_WDATA, ST_RDATA, ST_SKIP, ST_PROG
   } tws_state_e;

   typedef struct packed {
      tws_addr_t         addr;
      logic [DATA_W-1:0] data;
   } tws_wentry_s;

   typedef struct packed {
      logic              we;
      tws_addr_t         addr;
      logic [DATA_W-1:0] data;
   } tws_mem_wr_s;

endpackage
